// [rtl/cbm_csr_device.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Sixteen longword registers, eight-byte stride
// - Decode both I/O and memory space
// - Host uses only full longword accesses
// - Host writes reserved zero; reads arbitrary
// - Second I/O burst phase gets retry
// - Bit 20 sets descriptor byte order
// - Auto-poll transmit while suspended, nonzero field
// - Poll code selects interval; zero disables
// - Bit 16 widens window for diagnostics
// - Bursts stop at alignment boundary
// - Alignment codes give 8/16/32 longwords
// - Host programs alignment nonzero at start
// - Burst length zero: FIFO limited, 16
// - Burst length resets zero; legal values
// - Bit 7 reverses data buffer bytes
// - Host writes bus mode only when stopped
module cbm_csr_device #(
	parameter int unsigned TAP_200US_CYC = cbm_pkg::CBM_TAP_200US_CYC,
	parameter int unsigned TAP_800US_CYC = cbm_pkg::CBM_TAP_800US_CYC,
	parameter int unsigned TAP_1600US_CYC = cbm_pkg::CBM_TAP_1600US_CYC
) (
	input wire logic clk, // Bus clock
	input wire logic arst_n, // Async reset
	cbm_link_if.dev link, // Register access link
	input wire logic [31:0] io_base_address, // I/O space base
	input wire logic [31:0] memory_base_address, // Memory space base
	input wire logic tx_suspended, // Transmit idle, no buffer
	input wire logic [31:0] status_in, // Status register image
	input wire logic [31:0] missed_frames_in, // Missed frame counter image
	input wire logic [31:0] dma_addr, // Next DMA byte address
	input wire logic [6:0] fifo_lw, // FIFO longwords ready
	input wire logic [31:0] buf_data_in, // Buffer longword in
	input wire logic [31:0] desc_data_in, // Descriptor longword in
	output logic [31:0] bus_mode, // Bus mode register
	output logic [31:0] operation_mode, // Operation mode register
	output logic tx_poll_demand, // Transmit poll pulse
	output logic rx_poll_demand, // Receive poll pulse
	output logic [6:0] burst_len, // Longwords in next burst
	output logic burst_ok, // Bus request may be made
	output logic [31:0] buf_data_out, // Buffer longword ordered
	output logic [31:0] desc_data_out // Descriptor longword ordered
);
	import cbm_pkg::*;

	generate
		if (TAP_200US_CYC < 1 || TAP_200US_CYC > 65535 || TAP_800US_CYC < 1 || TAP_800US_CYC > 65535 ||
			TAP_1600US_CYC < 1 || TAP_1600US_CYC > 65535) begin : g_bad_tap
			$error("Poll interval counts must lie in 1..65535");
		end
	endgenerate

	function automatic logic [31:0] cbm_swap(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction : cbm_swap

	// ==================================================
	// Access link
	logic ack_r, ack_nxt;
	logic retry_r, retry_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic first_done_r, first_done_nxt;
	logic [31:0] bm_r, bm_nxt;
	logic [31:0] regs_r [CBM_NUM_REGS];
	logic [31:0] regs_nxt [CBM_NUM_REGS];
	logic txp_host, rxp_host;
	logic [31:0] io_off, mem_off, off32, window;
	logic [7:0] off;
	logic hit, req;
	logic [15:0] poll_cnt_r, poll_cnt_nxt;

	always_comb begin
		io_off = link.addr - io_base_address;
		mem_off = link.addr - memory_base_address;
		window = bm_r[CBM_BM_DIAG_BIT] ? CBM_DIAG_WINDOW : CBM_BASE_WINDOW;
		off32 = link.io_sel ? io_off : mem_off;
		hit = off32 < window;
		off = off32[7:0];
		req = link.phase && hit && !ack_r && !retry_r;
		ack_nxt = 1'b0;
		retry_nxt = 1'b0;
		rdata_nxt = rdata_r;
		first_done_nxt = link.cyc ? first_done_r : 1'b0;
		bm_nxt = bm_r;
		regs_nxt = regs_r;
		txp_host = 1'b0;
		rxp_host = 1'b0;
		if (req && link.io_sel && first_done_r) begin
			retry_nxt = 1'b1;
		end else if (req) begin
			ack_nxt = 1'b1;
			first_done_nxt = 1'b1;
			// Reserved bits of bus mode read back their reset ones
			if (off == CBM_OFF_BUS_MODE) begin
				rdata_nxt = bm_r;
			end else if (off == CBM_OFF_STATUS) begin
				rdata_nxt = status_in;
			end else if (off == CBM_OFF_MISSED) begin
				rdata_nxt = missed_frames_in;
			end else if (off == CBM_OFF_TX_POLL || off == CBM_OFF_RX_POLL) begin
				rdata_nxt = 32'h0000_0000;
			end else if (off < CBM_BASE_WINDOW[7:0]) begin
				rdata_nxt = regs_r[off[6:3]];
			end else if (off == CBM_OFF_DIAG_POLL) begin
				rdata_nxt = {16'h0000, poll_cnt_r};
			end else if (off == CBM_OFF_DIAG_BURST) begin
				rdata_nxt = {24'h00_0000, burst_ok, burst_len};
			end else begin
				rdata_nxt = 32'h0000_0000;
			end
			// Partial or misaligned writes are dropped
			if (link.wr && link.be_n == 4'h0 && off[2:0] == 3'h0 && off < CBM_BASE_WINDOW[7:0]) begin
				if (off == CBM_OFF_BUS_MODE) begin
					bm_nxt = (link.wdata & CBM_BM_WRITE_MASK) | (CBM_BM_RESET & ~CBM_BM_WRITE_MASK);
				end else if (off == CBM_OFF_TX_POLL) begin
					txp_host = 1'b1;
				end else if (off == CBM_OFF_RX_POLL) begin
					rxp_host = 1'b1;
				end else if (off != CBM_OFF_STATUS && off != CBM_OFF_MISSED) begin
					regs_nxt[off[6:3]] = link.wdata;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_r <= 1'b0;
			retry_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			first_done_r <= 1'b0;
			bm_r <= CBM_BM_RESET;
			for (int i = 0; i < CBM_NUM_REGS; i++) begin
				regs_r[i] <= 32'h0000_0000;
			end
		end else begin
			ack_r <= ack_nxt;
			retry_r <= retry_nxt;
			rdata_r <= rdata_nxt;
			first_done_r <= first_done_nxt;
			bm_r <= bm_nxt;
			regs_r <= regs_nxt;
		end
	end

	assign link.ack = ack_r;
	assign link.retry = retry_r;
	assign link.rdata = rdata_r;
	assign bus_mode = bm_r;
	assign operation_mode = regs_r[CBM_OFF_OP_MODE[6:3]];

	// ==================================================
	// Transmit auto-poll
	logic [2:0] tap;
	logic [15:0] poll_limit;
	logic tx_poll_r, tx_poll_nxt, rx_poll_r, rx_poll_nxt;

	always_comb begin
		tap = bm_r[CBM_BM_TAP_LSB +: 3];
		case (tap)
			3'h1: poll_limit = 16'(TAP_200US_CYC);
			3'h2: poll_limit = 16'(TAP_800US_CYC);
			3'h3: poll_limit = 16'(TAP_1600US_CYC);
			3'h4: poll_limit = 16'(CBM_TAP_12US8_CYC);
			3'h5: poll_limit = 16'(CBM_TAP_25US6_CYC);
			3'h6: poll_limit = 16'(CBM_TAP_51US2_CYC);
			3'h7: poll_limit = 16'(CBM_TAP_102US4_CYC);
			default: poll_limit = 16'h0000;
		endcase
		poll_cnt_nxt = 16'h0000;
		tx_poll_nxt = txp_host;
		rx_poll_nxt = rxp_host;
		// Count restarts whenever the transmitter leaves suspension
		if (tap != 3'h0 && tx_suspended) begin
			if (poll_cnt_r >= poll_limit - 16'h0001) begin
				tx_poll_nxt = 1'b1;
			end else begin
				poll_cnt_nxt = poll_cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			poll_cnt_r <= 16'h0000;
			tx_poll_r <= 1'b0;
			rx_poll_r <= 1'b0;
		end else begin
			poll_cnt_r <= poll_cnt_nxt;
			tx_poll_r <= tx_poll_nxt;
			rx_poll_r <= rx_poll_nxt;
		end
	end

	assign tx_poll_demand = tx_poll_r;
	assign rx_poll_demand = rx_poll_r;

	// ==================================================
	// DMA burst sizing and byte order
	logic [1:0] cal;
	logic [5:0] burst_lw, bound, to_bound, lw_mod;
	logic [6:0] len_nxt, len_r, limit;
	logic ok_nxt, ok_r;
	logic [31:0] buf_nxt, buf_r, desc_nxt, desc_r;

	always_comb begin
		cal = bm_r[CBM_BM_CAL_LSB +: 2];
		burst_lw = bm_r[CBM_BM_BURST_LSB +: 6];
		// Code 00 is illegal; treated as the smallest boundary
		if (cal == CBM_CAL_NONE || cal == CBM_CAL_8) begin
			bound = CBM_BOUND_8;
		end else if (cal == CBM_CAL_16) begin
			bound = CBM_BOUND_16;
		end else begin
			bound = CBM_BOUND_32;
		end
		lw_mod = dma_addr[7:2] & (bound - 6'h01);
		to_bound = bound - lw_mod;
		limit = (burst_lw != 6'h00) ? {1'b0, burst_lw} : fifo_lw;
		len_nxt = (limit < {1'b0, to_bound}) ? limit : {1'b0, to_bound};
		ok_nxt = (burst_lw == 6'h00) ? (fifo_lw >= CBM_FIFO_MIN_LW) : (fifo_lw != 7'h00);
		buf_nxt = bm_r[CBM_BM_BUF_ORDER_BIT] ? cbm_swap(buf_data_in) : buf_data_in;
		desc_nxt = bm_r[CBM_BM_DESC_ORDER_BIT] ? cbm_swap(desc_data_in) : desc_data_in;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			len_r <= 7'h00;
			ok_r <= 1'b0;
			buf_r <= 32'h0000_0000;
			desc_r <= 32'h0000_0000;
		end else begin
			len_r <= len_nxt;
			ok_r <= ok_nxt;
			buf_r <= buf_nxt;
			desc_r <= desc_nxt;
		end
	end

	assign burst_len = len_r;
	assign burst_ok = ok_r;
	assign buf_data_out = buf_r;
	assign desc_data_out = desc_r;
endmodule : cbm_csr_device

// [pkg/cbm_pkg.sv]
package cbm_pkg;
	// ==================================================
	// Register map
	localparam int unsigned CBM_NUM_REGS = 16;
	localparam int unsigned CBM_REG_STRIDE = 8;
	localparam logic [31:0] CBM_BASE_WINDOW = 32'h0000_0080;
	localparam logic [31:0] CBM_DIAG_WINDOW = 32'h0000_0100;
	localparam logic [7:0] CBM_OFF_BUS_MODE = 8'h00;
	localparam logic [7:0] CBM_OFF_TX_POLL = 8'h08;
	localparam logic [7:0] CBM_OFF_RX_POLL = 8'h10;
	localparam logic [7:0] CBM_OFF_RX_LIST = 8'h18;
	localparam logic [7:0] CBM_OFF_TX_LIST = 8'h20;
	localparam logic [7:0] CBM_OFF_STATUS = 8'h28;
	localparam logic [7:0] CBM_OFF_OP_MODE = 8'h30;
	localparam logic [7:0] CBM_OFF_INT_MASK = 8'h38;
	localparam logic [7:0] CBM_OFF_MISSED = 8'h40;
	localparam logic [7:0] CBM_OFF_ROM_CTRL = 8'h48;
	localparam logic [7:0] CBM_OFF_ROM_ADDR = 8'h50;
	localparam logic [7:0] CBM_OFF_TIMER = 8'h58;
	localparam logic [7:0] CBM_OFF_MA_STATUS = 8'h60;
	localparam logic [7:0] CBM_OFF_MA_CONN = 8'h68;
	localparam logic [7:0] CBM_OFF_MA_TXRX = 8'h70;
	localparam logic [7:0] CBM_OFF_MA_GEN = 8'h78;
	localparam logic [7:0] CBM_OFF_DIAG_POLL = 8'h80;
	localparam logic [7:0] CBM_OFF_DIAG_BURST = 8'h88;
	// ==================================================
	// Bus mode fields
	localparam int unsigned CBM_BM_DESC_ORDER_BIT = 20;
	localparam int unsigned CBM_BM_TAP_LSB = 17;
	localparam int unsigned CBM_BM_DIAG_BIT = 16;
	localparam int unsigned CBM_BM_CAL_LSB = 14;
	localparam int unsigned CBM_BM_BURST_LSB = 8;
	localparam int unsigned CBM_BM_BUF_ORDER_BIT = 7;
	localparam logic [31:0] CBM_BM_RESET = 32'hFFE0_0000;
	localparam logic [31:0] CBM_BM_WRITE_MASK = 32'h001F_FFFF;
	localparam logic [1:0] CBM_CAL_NONE = 2'h0;
	localparam logic [1:0] CBM_CAL_8 = 2'h1;
	localparam logic [1:0] CBM_CAL_16 = 2'h2;
	localparam logic [5:0] CBM_BOUND_8 = 6'h08;
	localparam logic [5:0] CBM_BOUND_16 = 6'h10;
	localparam logic [5:0] CBM_BOUND_32 = 6'h20;
	localparam logic [6:0] CBM_FIFO_MIN_LW = 7'h10;
	// ==================================================
	// Timing, clock period 100 ns
	localparam int unsigned CBM_CLK_NS = 100;
	localparam int unsigned CBM_TAP_200US_NS = 200000;
	localparam int unsigned CBM_TAP_800US_NS = 800000;
	localparam int unsigned CBM_TAP_1600US_NS = 1600000;
	localparam int unsigned CBM_TAP_12US8_NS = 12800;
	localparam int unsigned CBM_TAP_25US6_NS = 25600;
	localparam int unsigned CBM_TAP_51US2_NS = 51200;
	localparam int unsigned CBM_TAP_102US4_NS = 102400;
	localparam int unsigned CBM_TAP_200US_CYC = CBM_TAP_200US_NS / CBM_CLK_NS;
	localparam int unsigned CBM_TAP_800US_CYC = CBM_TAP_800US_NS / CBM_CLK_NS;
	localparam int unsigned CBM_TAP_1600US_CYC = CBM_TAP_1600US_NS / CBM_CLK_NS;
	localparam int unsigned CBM_TAP_12US8_CYC = CBM_TAP_12US8_NS / CBM_CLK_NS;
	localparam int unsigned CBM_TAP_25US6_CYC = CBM_TAP_25US6_NS / CBM_CLK_NS;
	localparam int unsigned CBM_TAP_51US2_CYC = CBM_TAP_51US2_NS / CBM_CLK_NS;
	localparam int unsigned CBM_TAP_102US4_CYC = CBM_TAP_102US4_NS / CBM_CLK_NS;
	localparam logic [4:0] CBM_HOST_TIMEOUT = 5'h10;
endpackage : cbm_pkg

// [pkg/cbm_link_if.sv]
`timescale 1ns/10ps
interface cbm_link_if;
	logic cyc;
	logic phase;
	logic io_sel;
	logic [31:0] addr;
	logic wr;
	logic [3:0] be_n;
	logic [31:0] wdata;
	logic ack;
	logic retry;
	logic [31:0] rdata;
	modport dev (input cyc, phase, io_sel, addr, wr, be_n, wdata, output ack, retry, rdata);
	modport host (output cyc, phase, io_sel, addr, wr, be_n, wdata, input ack, retry, rdata);
endinterface : cbm_link_if

// [rtl/cbm_csr_host.sv]
`timescale 1ns/10ps
module cbm_csr_host (
	input wire logic clk, // Bus clock
	input wire logic arst_n, // Async reset
	cbm_link_if.host link, // Register access link
	input wire logic [31:0] io_base_address, // I/O space base
	input wire logic [31:0] memory_base_address, // Memory space base
	input wire logic procs_stopped, // Transmit and receive stopped
	input wire logic cmd_valid, // Command offered
	output logic cmd_ready, // Command accepted
	input wire logic cmd_write, // Write, else read
	input wire logic cmd_io, // I/O space, else memory
	input wire logic [7:0] cmd_offset, // Register offset
	input wire logic [31:0] cmd_wdata, // Write data
	input wire logic cmd_two, // Two-phase burst
	output logic rsp_valid, // Response pulse
	output logic [31:0] rsp_rdata, // Last read data
	output logic rsp_error, // Refused or timed out
	output logic rsp_retried // A retry was seen
);
	import cbm_pkg::*;

	typedef enum {CBM_IDLE, CBM_PHASE, CBM_GAP, CBM_RESTART} cbm_host_e;

	cbm_host_e st_r, st_nxt;
	logic cyc_r, cyc_nxt, phase_r, phase_nxt, io_r, io_nxt, wr_r, wr_nxt;
	logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
	logic two_r, two_nxt;
	logic [4:0] tmo_r, tmo_nxt;
	logic rdy_r, rdy_nxt, rv_r, rv_nxt, err_r, err_nxt, rt_r, rt_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic bm_bad;
	logic [5:0] burst_lw;

	// ==================================================
	// Command sequencer
	always_comb begin
		burst_lw = cmd_wdata[CBM_BM_BURST_LSB +: 6];
		bm_bad = cmd_write && cmd_offset == CBM_OFF_BUS_MODE && (!procs_stopped ||
			cmd_wdata[CBM_BM_CAL_LSB +: 2] == CBM_CAL_NONE ||
			!(burst_lw == 6'h00 || burst_lw == 6'h01 || burst_lw == 6'h02 ||
			burst_lw == 6'h04 || burst_lw == 6'h08 || burst_lw == 6'h10));
		st_nxt = st_r;
		cyc_nxt = cyc_r;
		phase_nxt = phase_r;
		io_nxt = io_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		two_nxt = two_r;
		tmo_nxt = tmo_r;
		rdy_nxt = rdy_r;
		rv_nxt = 1'b0;
		err_nxt = err_r;
		rt_nxt = rt_r;
		rd_nxt = rd_r;
		case (st_r)
			CBM_IDLE: begin
				if (cmd_valid && rdy_r) begin
					rdy_nxt = 1'b0;
					if (bm_bad) begin
						rv_nxt = 1'b1;
						err_nxt = 1'b1;
						rt_nxt = 1'b0;
						rdy_nxt = 1'b1;
					end else begin
						st_nxt = CBM_PHASE;
						cyc_nxt = 1'b1;
						phase_nxt = 1'b1;
						io_nxt = cmd_io;
						wr_nxt = cmd_write;
						addr_nxt = (cmd_io ? io_base_address : memory_base_address) + {24'h00_0000, cmd_offset};
						// Reserved bus mode bits always go out as zero
						wdata_nxt = (cmd_offset == CBM_OFF_BUS_MODE) ? (cmd_wdata & CBM_BM_WRITE_MASK) : cmd_wdata;
						two_nxt = cmd_two;
						tmo_nxt = 5'h00;
						err_nxt = 1'b0;
						rt_nxt = 1'b0;
					end
				end
			end
			CBM_PHASE: begin
				tmo_nxt = tmo_r + 5'h01;
				phase_nxt = 1'b0;
				if (link.ack) begin
					rd_nxt = link.rdata;
					tmo_nxt = 5'h00;
					if (two_r) begin
						two_nxt = 1'b0;
						addr_nxt = addr_r + 32'h0000_0008;
						st_nxt = CBM_GAP;
					end else begin
						cyc_nxt = 1'b0;
						rv_nxt = 1'b1;
						rdy_nxt = 1'b1;
						st_nxt = CBM_IDLE;
					end
				end else if (link.retry) begin
					cyc_nxt = 1'b0;
					rt_nxt = 1'b1;
					tmo_nxt = 5'h00;
					st_nxt = CBM_RESTART;
				end else if (tmo_r == CBM_HOST_TIMEOUT) begin
					cyc_nxt = 1'b0;
					rv_nxt = 1'b1;
					err_nxt = 1'b1;
					rdy_nxt = 1'b1;
					st_nxt = CBM_IDLE;
				end else begin
					phase_nxt = 1'b1;
				end
			end
			CBM_GAP, CBM_RESTART: begin
				cyc_nxt = 1'b1;
				phase_nxt = 1'b1;
				st_nxt = CBM_PHASE;
			end
			default: st_nxt = CBM_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= CBM_IDLE;
			cyc_r <= 1'b0;
			phase_r <= 1'b0;
			io_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			two_r <= 1'b0;
			tmo_r <= 5'h00;
			rdy_r <= 1'b1;
			rv_r <= 1'b0;
			err_r <= 1'b0;
			rt_r <= 1'b0;
			rd_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			cyc_r <= cyc_nxt;
			phase_r <= phase_nxt;
			io_r <= io_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			two_r <= two_nxt;
			tmo_r <= tmo_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
			err_r <= err_nxt;
			rt_r <= rt_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign link.cyc = cyc_r;
	assign link.phase = phase_r;
	assign link.io_sel = io_r;
	assign link.addr = addr_r;
	assign link.wr = wr_r;
	assign link.be_n = 4'h0;
	assign link.wdata = wdata_r;
	assign cmd_ready = rdy_r;
	assign rsp_valid = rv_r;
	assign rsp_rdata = rd_r;
	assign rsp_error = err_r;
	assign rsp_retried = rt_r;
endmodule : cbm_csr_host

// [testbench/cbm_checker.sv]
`timescale 1ns/10ps
// ==========
// Link protocol checks
module cbm_checker #(
	parameter logic [31:0] IO_BASE = 32'h0000_1000,
	parameter logic [31:0] MEM_BASE = 32'h0000_2000
) (
	input wire logic clk, // Bus clock
	input wire logic arst_n, // Async reset
	input wire logic cyc, // Transaction open
	input wire logic phase, // Phase request
	input wire logic io_sel, // I/O space
	input wire logic [31:0] addr, // Byte address
	input wire logic wr, // Write
	input wire logic ack, // Phase done
	input wire logic retry, // Phase refused
	input wire logic [31:0] rdata // Read data
);
	logic acked_r;
	logic acked_nxt;
	logic [31:0] rel;
	assign rel = addr - (io_sel ? IO_BASE : MEM_BASE);
	// Remembers an acked phase until the transaction closes
	always_comb begin
		acked_nxt = cyc & (acked_r | ack);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acked_r <= 1'b0;
		end else begin
			acked_r <= acked_nxt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Taken only while no answer stands
	sequence s_take;
		phase && !ack && !retry;
	endsequence
	sequence s_answer;
		ack || retry;
	endsequence
	AST_HIT_ANSWER: assert property (s_take ##0 (rel < 32'h80) |=> s_answer)
		else $error("window hit not answered");
	AST_MISS_SILENT: assert property (s_take ##0 (rel >= 32'h100) |=> !(ack || retry))
		else $error("address outside window answered");
	AST_IO_RETRY: assert property (s_take ##0 (io_sel && acked_r) |=> retry)
		else $error("second io phase not retried");
	AST_MEM_NO_RETRY: assert property (s_take ##0 !io_sel |=> !retry)
		else $error("memory phase retried");
	AST_FIRST_ACK: assert property (s_take ##0 (!acked_r && rel < 32'h80) |=> ack)
		else $error("first phase not acked");
	AST_ACK_CAUSED: assert property (ack |-> $past(phase && !ack && !retry))
		else $error("ack without request");
	AST_ONE_ANSWER: assert property (s_answer |=> !(ack || retry))
		else $error("answer longer than one cycle");
	AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
		else $error("read data moved without ack");
	AST_BM_RESERVED: assert property (ack && !wr && rel == 32'h0 |-> rdata[31:21] == 11'h7FF)
		else $error("bus mode reserved bits wrong");
endmodule : cbm_checker

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
	import cbm_pkg::*;
	localparam logic [31:0] IO_B = 32'h0000_1000;
	localparam logic [31:0] MEM_B = 32'h0000_2000;
	logic clk, arst_n, tx_susp, procs_stopped, cmd_valid, cmd_ready, cmd_write, cmd_io, cmd_two;
	logic rsp_valid, rsp_error, rsp_retried, txp, rxp, burst_ok;
	logic [7:0] cmd_offset;
	logic [6:0] fifo_lw, burst_len;
	logic [31:0] cmd_wdata, status_in, missed_in, dma_addr, buf_in, desc_in, bus_mode, op_mode, op2;
	logic [31:0] buf_out, desc_out, rsp_rdata, bm, d;
	logic [31:0] regs [16];
	int n_mismatch = 0, comparisons = 0, n_txp = 0, n_rxp = 0, n;
	int per [8] = '{0, 20, 40, 80, 128, 256, 512, 1024};
	logic [31:0] bad [3] = '{32'h0000_0100, 32'h0000_4300, 32'h0000_4100};
	logic [5:0] pbls [6] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
	cbm_link_if link_a();
	cbm_link_if link_b();
	cbm_csr_device #(.TAP_200US_CYC(20), .TAP_800US_CYC(40), .TAP_1600US_CYC(80)) u_cbm_csr_device (
		.clk(clk), .arst_n(arst_n), .link(link_a), .io_base_address(IO_B), .memory_base_address(MEM_B),
		.tx_suspended(tx_susp), .status_in(status_in), .missed_frames_in(missed_in), .dma_addr(dma_addr),
		.fifo_lw(fifo_lw), .buf_data_in(buf_in), .desc_data_in(desc_in), .bus_mode(bus_mode),
		.operation_mode(op_mode), .tx_poll_demand(txp), .rx_poll_demand(rxp), .burst_len(burst_len),
		.burst_ok(burst_ok), .buf_data_out(buf_out), .desc_data_out(desc_out));
	// Second end faces a raw driver that breaks the longword rule
	cbm_csr_device u_cbm_csr_device_2 (
		.clk(clk), .arst_n(arst_n), .link(link_b), .io_base_address(IO_B), .memory_base_address(MEM_B),
		.tx_suspended(tx_susp), .status_in(status_in), .missed_frames_in(missed_in), .dma_addr(dma_addr),
		.fifo_lw(fifo_lw), .buf_data_in(buf_in), .desc_data_in(desc_in), .bus_mode(),
		.operation_mode(op2), .tx_poll_demand(), .rx_poll_demand(), .burst_len(),
		.burst_ok(), .buf_data_out(), .desc_data_out());
	cbm_csr_host u_cbm_csr_host (
		.clk(clk), .arst_n(arst_n), .link(link_a), .io_base_address(IO_B), .memory_base_address(MEM_B),
		.procs_stopped(procs_stopped), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_io(cmd_io), .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .cmd_two(cmd_two),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .rsp_retried(rsp_retried));
	cbm_checker #(.IO_BASE(IO_B), .MEM_BASE(MEM_B)) u_cbm_checker (
		.clk(clk), .arst_n(arst_n), .cyc(link_a.cyc), .phase(link_a.phase), .io_sel(link_a.io_sel),
		.addr(link_a.addr), .wr(link_a.wr), .ack(link_a.ack), .retry(link_a.retry), .rdata(link_a.rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (txp === 1'b1) n_txp <= n_txp + 1;
		if (rxp === 1'b1) n_rxp <= n_rxp + 1;
	end
	// ==========
	// Helpers
	task automatic test_done();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic cmd(input logic w, input logic io, input logic [7:0] off, input logic [31:0] v, input logic two);
		int k;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_io <= io;
		cmd_offset <= off;
		cmd_wdata <= v;
		cmd_two <= two;
		k = 0;
		do begin @(posedge clk); k++; end while (cmd_ready !== 1'b1 && k < 99);
		cmd_valid <= 1'b0;
		do begin @(posedge clk); k++; end while (rsp_valid !== 1'b1 && k < 99);
		if (k >= 99) begin
			n_mismatch++;
			test_done();
		end
	endtask : cmd
	task automatic wr_bm(input logic [31:0] v);
		cmd(1'b1, 1'b0, 8'h00, v, 1'b0);
		bm = 32'hFFE0_0000 | v;
		chk("bus_mode", bus_mode, bm);
	endtask : wr_bm
	// Cycles up to the next poll pulse
	task automatic gap();
		n = 0;
		do begin @(posedge clk); n++; end while (txp !== 1'b1 && n < 1100);
		if (n >= 1100) begin
			n_mismatch++;
			test_done();
		end
	endtask : gap
	function automatic logic [31:0] bswap(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : bswap
	function automatic logic [31:0] exp_rd(input logic [7:0] off);
		case (off)
			8'h00: return bm;
			8'h08, 8'h10: return 32'h0;
			8'h28: return status_in;
			8'h40: return missed_in;
			default: return regs[off[6:3]];
		endcase
	endfunction : exp_rd
	function automatic int exp_len();
		int b, lim, rem;
		b = (bm[15:14] == 2'h3) ? 32 : (bm[15:14] == 2'h2) ? 16 : 8;
		lim = (bm[13:8] != 6'h0) ? int'(bm[13:8]) : int'(fifo_lw);
		rem = b - (int'(dma_addr[7:2]) % b);
		return (lim < rem) ? lim : rem;
	endfunction : exp_len
	// ==========
	// Main sequence
	initial begin
		arst_n = 1'b0;
		tx_susp = 1'b0;
		procs_stopped = 1'b1;
		{cmd_valid, cmd_write, cmd_io, cmd_two, cmd_offset, cmd_wdata} = '0;
		{status_in, missed_in, dma_addr, buf_in, desc_in, fifo_lw} = '0;
		{link_b.cyc, link_b.phase, link_b.io_sel, link_b.addr, link_b.wr, link_b.be_n, link_b.wdata} = '0;
		n = $urandom(9);
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		status_in <= $urandom;
		missed_in <= $urandom;
		@(posedge clk);
		chk("bm_reset", bus_mode, 32'hFFE0_0000);
		bm = 32'hFFE0_0000;
		cmd(1'b0, 1'b1, 8'h00, 32'h0, 1'b0);
		chk("bm_read", rsp_rdata, bm);
		for (int i = 1; i < 16; i++) begin
			regs[i] = $urandom;
			cmd(1'b1, 1'(i), 8'(i * 8), regs[i], 1'b0);
		end
		for (int i = 1; i < 16; i++) begin
			cmd(1'b0, 1'(~i), 8'(i * 8), 32'h0, 1'b0);
			chk("csr_read", rsp_rdata, exp_rd(8'(i * 8)));
		end
		chk("op_mode", op_mode, regs[6]);
		chk("poll_pulses", 32'(n_txp * 2 + n_rxp), 32'h3);
		for (int i = 0; i < 12; i++) begin
			d = $urandom & 32'h001F_00FF;
			d[15:14] = 2'(i % 3 + 1);
			d[13:8] = pbls[i % 6];
			wr_bm(d);
			cmd(1'b0, 1'(i), 8'h00, 32'h0, 1'b0);
			chk("bm_readback", rsp_rdata, bm);
			for (int j = 0; j < 3; j++) begin
				dma_addr <= $urandom;
				fifo_lw <= (j == 0) ? 7'(15 + i % 2) : 7'($urandom);
				buf_in <= $urandom;
				desc_in <= $urandom;
				repeat (2) @(posedge clk);
				chk("burst_len", 32'(burst_len), exp_len());
				chk("burst_ok", 32'(burst_ok), 32'((bm[13:8] == 6'h0) ? fifo_lw >= 7'h10 : fifo_lw != 7'h0));
				chk("buf_order", buf_out, bm[7] ? bswap(buf_in) : buf_in);
				chk("desc_order", desc_out, bm[20] ? bswap(desc_in) : desc_in);
			end
		end
		for (int i = 0; i < 3; i++) begin
			procs_stopped <= (i != 2);
			cmd(1'b1, 1'b0, 8'h00, bad[i], 1'b0);
			chk("bm_refused", 32'(rsp_error), 32'h1);
			chk("bm_kept", bus_mode, bm);
		end
		procs_stopped <= 1'b1;
		cmd(1'b0, 1'b1, 8'h18, 32'h0, 1'b1);
		chk("io_retry", 32'(rsp_retried), 32'h1);
		chk("io_burst", rsp_rdata, regs[4]);
		cmd(1'b0, 1'b0, 8'h18, 32'h0, 1'b1);
		chk("mem_retry", 32'(rsp_retried), 32'h0);
		chk("mem_burst", rsp_rdata, regs[4]);
		wr_bm(32'h0000_4100);
		cmd(1'b0, 1'b0, 8'h80, 32'h0, 1'b0);
		chk("diag_off", 32'(rsp_error), 32'h1);
		wr_bm(32'h0001_4100);
		cmd(1'b0, 1'b1, 8'h80, 32'h0, 1'b0);
		chk("diag_on", 32'(rsp_error), 32'h0);
		chk("diag_poll", rsp_rdata, 32'h0);
		cmd(1'b0, 1'b0, 8'h88, 32'h0, 1'b0);
		chk("diag_burst", rsp_rdata, {24'h00_0000, fifo_lw != 7'h00, 7'(exp_len())});
		cmd(1'b0, 1'b0, 8'hF8, 32'h0, 1'b1);
		chk("diag_edge", 32'(rsp_error), 32'h1);
		for (int c = 0; c < 8; c++) begin
			wr_bm(32'h0000_4100 | (32'(c) << 17));
			tx_susp <= 1'b1;
			n = n_txp;
			if (c == 0) begin
				repeat (1100) @(posedge clk);
				chk("tap_off", 32'(n_txp - n), 32'h0);
			end else begin
				gap();
				gap();
				chk("tap_period", 32'(n), 32'(per[c]));
			end
			tx_susp <= 1'b0;
		end
		@(posedge clk);
		link_b.cyc <= 1'b1;
		link_b.phase <= 1'b1;
		link_b.addr <= MEM_B + 32'h30;
		link_b.wr <= 1'b1;
		link_b.be_n <= 4'h1;
		link_b.wdata <= 32'hA5A5_5A5A;
		n = 0;
		do begin @(posedge clk); n++; end while (link_b.ack !== 1'b1 && n < 20);
		link_b.phase <= 1'b0;
		link_b.cyc <= 1'b0;
		@(posedge clk);
		chk("partial_ack", 32'(n < 20), 32'h1);
		chk("partial_write", op2, 32'h0);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		chk("bm_reset2", bus_mode, 32'hFFE0_0000);
		test_done();
	end
endmodule : tb
